// ===== hw/pwt_pkg.sv
/*
  Constants, types and helpers for the pulse-width trigger compare block.
  Assumes a single 25 MHz system clock and a 32-bit Wishbone register bus.
*/
package pwt_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PWT_DW = 32;
  localparam int PWT_AW = 8;
  localparam int PWT_CH = 4;
  localparam int PWT_NEV = 5;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] PWT_IDX_MULT = 6'h1E;
  localparam logic [5:0] PWT_IDX_CTL0 = 6'h20;
  localparam logic [5:0] PWT_IDX_CTL1 = 6'h21;
  localparam logic [5:0] PWT_IDX_CTL2 = 6'h22;
  localparam logic [5:0] PWT_IDX_CTL3 = 6'h23;
  localparam logic [5:0] PWT_IDX_STAT = 6'h24;
  localparam logic [5:0] PWT_IDX_MASK = 6'h25;
  localparam logic [5:0] PWT_IDX_ACQ = 6'h26;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PWT_THR_LSB = 16;
  localparam int PWT_THR_MSB = 31;
  localparam int PWT_MODE_LSB = 0;
  localparam int PWT_MODE_MSB = 1;
  localparam int PWT_ACQ_EN_BIT = 0;
  localparam int PWT_ACQ_RUN_BIT = 1;
  localparam int PWT_EV_START_BIT = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PWT_THR_RST = 16'h0000;
  localparam logic [1:0] PWT_MODE_RST = 2'h0;
  localparam logic [31:0] PWT_MULT_RST = 32'h0000_0000;
  localparam logic [4:0] PWT_EV_RST = 5'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PWT_CLK_NS = 40;
  localparam int PWT_UNIT_NS = 2000;
  localparam int PWT_UNIT_CYC = PWT_UNIT_NS / PWT_CLK_NS;
  localparam int PWT_UNIT_W = 6;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWT_MODE_OFF = 2'h0,
    PWT_MODE_GT = 2'h1,
    PWT_MODE_LE = 2'h2,
    PWT_MODE_RSV = 2'h3
  } pwt_mode_t;

  typedef enum logic [1:0] {
    PWT_ST_IDLE = 2'b01,
    PWT_ST_RUN = 2'b10
  } pwt_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] pwt_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic pwt_match(input logic [15:0] width,
                                     input logic [15:0] thr,
                                     input logic [1:0] mode);
    logic r;
    r = 1'b0;
    case (mode)
      PWT_MODE_GT: r = width > thr; // R7
      PWT_MODE_LE: r = width <= thr; // R8
      default: r = 1'b0; // R6 R10
    endcase
    return r;
  endfunction

endpackage

// ===== hw/pwt_channel.sv
/*
  One pulse-width trigger comparator channel.
  Assumes the measurement is synchronous to clk_i and held stable per cycle.
*/
module pwt_channel
  import pwt_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Measurement and setup
  input wire logic [31:0] width_i,
  input wire logic [15:0] thr_i,
  input wire logic [1:0] mode_i,
  // Trigger event
  output logic fire_o
);

  logic match_next;
  logic match_reg;
  logic fire_reg;

  // ----------------------------------------------------------------
  // Compare on low half of measurement
  // ----------------------------------------------------------------
  assign match_next = pwt_match(width_i[15:0], thr_i, mode_i); // R4

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_reg <= 1'b0;
      fire_reg <= 1'b0;
    end else begin
      match_reg <= match_next;
      fire_reg <= match_next & ~match_reg; // R3
    end
  end

  assign fire_o = fire_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_never_fire: assert property ( // R6
    (mode_i == PWT_MODE_OFF || mode_i == PWT_MODE_RSV) |=> !fire_o
  ) else $error("channel fired while disabled");

  chk_gt_fire: assert property ( // R7
    fire_o && $past(mode_i) == PWT_MODE_GT
      |-> $past(width_i[15:0]) > $past(thr_i)
  ) else $error("greater-than fire without cause");

  chk_le_fire: assert property ( // R8
    fire_o && $past(mode_i) == PWT_MODE_LE
      |-> $past(width_i[15:0]) <= $past(thr_i)
  ) else $error("less-equal fire without cause");

  chk_fire_edge: assert property ( // R3
    fire_o |=> !fire_o
  ) else $error("fire longer than one cycle");

  chk_high_ignored: assert property ( // R4
    fire_o |-> $past(pwt_match(width_i[15:0], thr_i, mode_i))
  ) else $error("fire not from low 16 bits");

endmodule

// ===== hw/pwt_compare.sv
/*
  Four-channel pulse-width trigger compare with acquisition start and
  sampling clock, reached over a classic Wishbone slave.
  Assumes all inputs synchronous to clk_i; other trigger sources are
  single-cycle or level requests from neighbouring blocks.
*/
// Overview of operation
// R1 - Four independent channels each have a control register at 0x20-0x23.
// R2 - A channel firing starts the sampling clock for continuous sampling.
// R3 - A channel fires when its configured comparison becomes true.
// R4 - Only the low 16 bits of the width measurement are compared.
// R5 - Control bits 31:16 hold a read/write 16-bit threshold.
// R6 - Trigger type 00 never fires.
// R7 - Trigger type 01 fires when width is greater than the threshold.
// R8 - Trigger type 10 fires when width is at or below the threshold.
// R9 - Software picks the measurement clock so widths fit in 16 bits.
// R10 - Type 11 never fires and control bits 15:2 read zero.
// R11 - Acquisition start is the OR of all four trigger source kinds.
// R12 - Sample period is (multiplier plus one) times two microseconds.
module pwt_compare
  import pwt_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pwt_pkg::PWT_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [pwt_pkg::PWT_DW-1:0] wb_dat_i,
  output logic [pwt_pkg::PWT_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Pulse width measurements
  input wire logic [31:0] pulse_input_0_i,
  input wire logic [31:0] pulse_input_1_i,
  input wire logic [31:0] pulse_input_2_i,
  input wire logic [31:0] pulse_input_3_i,
  // Other trigger sources
  input wire logic dig_trig_i,
  input wire logic adc_trig_i,
  input wire logic enc_trig_i,
  // Acquisition
  output logic acq_start_o,
  output logic acq_active_o,
  output logic sample_clk_o,
  // Interrupt
  output logic irq_o
);
  import pwt_pkg::*;

  logic ack_reg;
  logic [31:0] dat_reg;
  logic [15:0] thr_reg [PWT_CH];
  logic [1:0] mode_reg [PWT_CH];
  logic [31:0] mult_reg;
  logic en_reg;
  logic [4:0] status_reg;
  logic [4:0] mask_reg;
  logic irq_reg;
  pwt_state_t state_reg;
  pwt_state_t state_next;
  logic start_reg;
  logic tick_reg;
  logic [PWT_UNIT_W-1:0] unit_cnt;
  logic [31:0] mult_cnt;
  logic [PWT_CH-1:0] ch_fire;
  logic [31:0] ch_width [PWT_CH];
  logic req;
  logic wr_go;
  logic [5:0] idx;
  logic [31:0] rd_next;
  logic start_any;
  logic unit_last;
  logic [4:0] ev_set;
  logic [31:0] ctl_wr;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  assign ch_width[0] = pulse_input_0_i;
  assign ch_width[1] = pulse_input_1_i;
  assign ch_width[2] = pulse_input_2_i;
  assign ch_width[3] = pulse_input_3_i;

  for (genvar g = 0; g < PWT_CH; g++) begin : g_ch
    pwt_channel u_ch ( // R1
      .clk_i(clk_i),
      .rst_i(rst_i),
      .width_i(ch_width[g]),
      .thr_i(thr_reg[g]),
      .mode_i(mode_reg[g]),
      .fire_o(ch_fire[g])
    );
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[7:2];
  // Writes land on the edge where the master sees ack
  assign wr_go = req & wb_we_i & ack_reg;

  always_comb begin
    rd_next = 32'h0000_0000;
    case (idx)
      PWT_IDX_CTL0, PWT_IDX_CTL1, PWT_IDX_CTL2, PWT_IDX_CTL3: begin
        rd_next[PWT_THR_MSB:PWT_THR_LSB] = thr_reg[idx[1:0]]; // R5
        rd_next[PWT_MODE_MSB:PWT_MODE_LSB] = mode_reg[idx[1:0]]; // R10
      end
      PWT_IDX_MULT: rd_next = mult_reg;
      PWT_IDX_STAT: rd_next[4:0] = status_reg;
      PWT_IDX_MASK: rd_next[4:0] = mask_reg;
      PWT_IDX_ACQ: begin
        rd_next[PWT_ACQ_EN_BIT] = en_reg;
        rd_next[PWT_ACQ_RUN_BIT] = state_reg == PWT_ST_RUN;
      end
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req & ~ack_reg) begin
        dat_reg <= rd_next;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ----------------------------------------------------------------
  // Channel control registers
  // ----------------------------------------------------------------
  // Bits 15:2 are not stored
  assign ctl_wr = pwt_merge({thr_reg[idx[1:0]], 14'h0000,
                             mode_reg[idx[1:0]]}, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PWT_CH; i++) begin
        thr_reg[i] <= PWT_THR_RST;
        mode_reg[i] <= PWT_MODE_RST;
      end
    end else if (wr_go && idx[5:2] == PWT_IDX_CTL0[5:2]) begin
      thr_reg[idx[1:0]] <= ctl_wr[PWT_THR_MSB:PWT_THR_LSB]; // R5
      mode_reg[idx[1:0]] <= ctl_wr[PWT_MODE_MSB:PWT_MODE_LSB]; // R10
    end
  end

  // ----------------------------------------------------------------
  // Multiplier and acquisition control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mult_reg <= PWT_MULT_RST;
    end else if (wr_go && idx == PWT_IDX_MULT) begin
      mult_reg <= pwt_merge(mult_reg, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_reg <= 1'b0;
    end else if (wr_go && idx == PWT_IDX_ACQ && wb_sel_i[0]) begin
      en_reg <= wb_dat_i[PWT_ACQ_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Acquisition state
  // ----------------------------------------------------------------
  assign start_any = dig_trig_i | adc_trig_i | enc_trig_i | (|ch_fire); // R11

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PWT_ST_IDLE: begin
        if (en_reg && start_any) begin
          state_next = PWT_ST_RUN; // R2
        end
      end
      PWT_ST_RUN: begin
        if (!en_reg) begin
          state_next = PWT_ST_IDLE;
        end
      end
      default: state_next = PWT_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= PWT_ST_IDLE;
      start_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      start_reg <= state_reg == PWT_ST_IDLE && state_next == PWT_ST_RUN;
    end
  end

  assign acq_start_o = start_reg;
  // One-hot run bit of the state flop
  assign acq_active_o = state_reg[1];

  // ----------------------------------------------------------------
  // Sampling clock
  // ----------------------------------------------------------------
  assign unit_last = unit_cnt == PWT_UNIT_W'(PWT_UNIT_CYC - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg != PWT_ST_RUN) begin
      unit_cnt <= '0;
      mult_cnt <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (unit_last) begin
        unit_cnt <= '0;
        if (mult_cnt >= mult_reg) begin
          mult_cnt <= 32'h0000_0000;
          tick_reg <= 1'b1; // R12
        end else begin
          mult_cnt <= mult_cnt + 32'h0000_0001;
        end
      end else begin
        unit_cnt <= unit_cnt + PWT_UNIT_W'(1);
      end
    end
  end

  assign sample_clk_o = tick_reg;

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  assign ev_set = {start_reg, ch_fire};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= PWT_EV_RST;
      mask_reg <= PWT_EV_RST;
      irq_reg <= 1'b0;
    end else begin
      // A new event wins over a clear in the same cycle
      if (wr_go && idx == PWT_IDX_STAT && wb_sel_i[0]) begin
        status_reg <= (status_reg & ~wb_dat_i[4:0]) | ev_set;
      end else begin
        status_reg <= status_reg | ev_set;
      end
      if (wr_go && idx == PWT_IDX_MASK && wb_sel_i[0]) begin
        mask_reg <= wb_dat_i[4:0];
      end
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  assign irq_o = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [39:0] gap_cnt;
  logic gap_valid;

  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg != PWT_ST_RUN ||
        (wr_go && idx == PWT_IDX_MULT)) begin
      gap_cnt <= 40'h00_0000_0000;
      gap_valid <= 1'b0;
    end else if (tick_reg) begin
      gap_cnt <= 40'h00_0000_0001;
      gap_valid <= 1'b1;
    end else begin
      gap_cnt <= gap_cnt + 40'h00_0000_0001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_or_start: assert property ( // R11
    state_reg == PWT_ST_IDLE && en_reg && start_any |=> acq_start_o
  ) else $error("trigger source did not start acquisition");

  chk_start_run: assert property ( // R2
    acq_start_o |-> acq_active_o ##1 (acq_active_o || !en_reg)
  ) else $error("start without sampling clock running");

  chk_fire_starts: assert property ( // R2
    state_reg == PWT_ST_IDLE && en_reg && (|ch_fire)
      |=> acq_active_o ##[1:50] (unit_last || !acq_active_o)
  ) else $error("channel fire did not start sampling");

  chk_period_len: assert property ( // R12
    sample_clk_o && gap_valid
      |-> gap_cnt == ({8'h00, mult_reg} + 40'h00_0000_0001)
                     * 40'(PWT_UNIT_CYC)
  ) else $error("sample period wrong");

  chk_ctl_reserved: assert property ( // R10
    wb_ack_o && $past(idx[5:2]) == PWT_IDX_CTL0[5:2]
      |-> wb_dat_o[15:2] == 14'h0000
  ) else $error("control reserved bits not zero");

  chk_ack_once: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held for more than one cycle");

  chk_irq_level: assert property (
    $rose(irq_o) |-> $past(|(status_reg & mask_reg))
  ) else $error("interrupt without cause");

  chk_status_sticky: assert property (
    (|ch_fire) |=> (status_reg[3:0] & $past(ch_fire)) == $past(ch_fire)
  ) else $error("channel event not recorded");

  cov_ch_fire: cover property (|ch_fire);
  cov_acq_start: cover property (acq_start_o ##[1:100] sample_clk_o);
  cov_irq: cover property ($rose(irq_o));
  cov_stop: cover property (acq_active_o ##1 !acq_active_o);

endmodule

// ===== verification/pwt_pulse_model.sv
/*
  Model of the pulse width measurement sources on the far side.
  Assumes the bench loads one channel width per load_i cycle.
*/
module pwt_pulse_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Load request
  input wire logic load_i,
  input wire logic [1:0] ch_i,
  input wire logic [31:0] width_i,
  // Measurements
  output logic [31:0] width0_o,
  output logic [31:0] width1_o,
  output logic [31:0] width2_o,
  output logic [31:0] width3_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Widths change only at a clock edge, like a synchronous counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      width0_o <= 32'h0000_0000;
      width1_o <= 32'h0000_0000;
      width2_o <= 32'h0000_0000;
      width3_o <= 32'h0000_0000;
    end else if (load_i) begin
      // Upper bits only nonzero when a scenario asks for overflow
      case (ch_i)
        2'h0: width0_o <= width_i;
        2'h1: width1_o <= width_i;
        2'h2: width2_o <= width_i;
        default: width3_o <= width_i;
      endcase
    end
  end
endmodule

// ===== verification/test_pulse_width_trigger_compare.sv
/*
  Self-checking bench for the pulse-width trigger compare block.
  Assumes the design answers Wishbone one cycle after a request.
*/
module test_pulse_width_trigger_compare
  import pwt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0000_0000, dat_r;
  logic ack, acq_start, acq_active, sclk, irq;
  logic load = 1'b0;
  logic [1:0] wch = 2'h0;
  logic [31:0] wv = 32'h0000_0000, w0, w1, w2, w3;
  logic dig = 1'b0, adc = 1'b0, enc = 1'b0;
  int miscompares = 0;
  int n_compared = 0;

  always #20 clk_i = ~clk_i;

  pwt_pulse_model u_src (.clk_i(clk_i), .rst_i(rst_i), .load_i(load),
    .ch_i(wch), .width_i(wv), .width0_o(w0), .width1_o(w1),
    .width2_o(w2), .width3_o(w3));

  pwt_compare dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .pulse_input_0_i(w0), .pulse_input_1_i(w1), .pulse_input_2_i(w2),
    .pulse_input_3_i(w3), .dig_trig_i(dig), .adc_trig_i(adc),
    .enc_trig_i(enc), .acq_start_o(acq_start), .acq_active_o(acq_active),
    .sample_clk_o(sclk), .irq_o(irq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [5:0] idx,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    dat_w <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      check(32'h0000_0000, 32'h0000_0001);
    end
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [5:0] idx, output logic [31:0] q);
    wb(1'b0, idx, 32'h0000_0000, q);
  endtask

  task automatic set_width(input int ch, input logic [31:0] w);
    @(posedge clk_i);
    load <= 1'b1;
    wch <= 2'(ch);
    wv <= w;
    @(posedge clk_i);
    load <= 1'b0;
  endtask

  // Program a channel, make its compare rise, return status
  task automatic trig(input int ch, input logic [1:0] m,
                      input logic [31:0] wf, input logic [31:0] wt,
                      output logic [31:0] q);
    wr(PWT_IDX_CTL0 + 6'(ch), {16'h0064, 14'h0000, m});
    set_width(ch, wf);
    repeat (3) @(posedge clk_i);
    wr(PWT_IDX_STAT, 32'h0000_001F);
    set_width(ch, wt);
    repeat (4) @(posedge clk_i);
    rd(PWT_IDX_STAT, q);
  endtask

  task automatic wait_start(output logic got);
    got = 1'b0;
    repeat (20) begin
      @(posedge clk_i);
      if (acq_start === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask

  task automatic count_sclk(output logic [31:0] n);
    n = 32'h0000_0000;
    do begin
      @(posedge clk_i);
      n++;
    end while (sclk !== 1'b1 && n < 32'h0000_012C);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic got;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(PWT_IDX_CTL0 + 6'(i), q);
      check(q, 32'h0000_0000);
      wr(PWT_IDX_CTL0 + 6'(i), {16'hA5C0 + 16'(i), 16'hFFFF});
      rd(PWT_IDX_CTL0 + 6'(i), q);
      check(q, {16'hA5C0 + 16'(i), 16'h0003});
    end
    rd(6'h3F, q);
    check(q, 32'h0000_0000);
    wr(PWT_IDX_MASK, 32'h0000_001F);
    for (int i = 0; i < 4; i++) begin
      trig(i, 2'h1, 32'h0000_0064, 32'h0000_0065, q);
      check(q, 32'h0000_0001 << i);
    end
    trig(0, 2'h1, 32'h0000_0000, 32'h0000_0064, q);
    check(q, 32'h0000_0000);
    trig(1, 2'h2, 32'h0000_0065, 32'h0000_0064, q);
    check(q, 32'h0000_0002);
    trig(1, 2'h2, 32'h0000_00C8, 32'h0000_0065, q);
    check(q, 32'h0000_0000);
    trig(2, 2'h0, 32'h0000_0000, 32'h0000_01F4, q);
    check(q, 32'h0000_0000);
    trig(3, 2'h3, 32'h0000_0000, 32'h0000_01F4, q);
    check(q, 32'h0000_0000);
    trig(3, 2'h3, 32'h0000_01F4, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    trig(0, 2'h1, 32'h0000_0000, 32'h0001_0032, q);
    check(q, 32'h0000_0000);
    trig(0, 2'h2, 32'h0000_00C8, 32'h0003_0032, q);
    check(q, 32'h0000_0001);
    check(32'(irq), 32'h0000_0001);
    wr(PWT_IDX_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    check(32'(irq), 32'h0000_0000);
    wr(PWT_IDX_MASK, 32'h0000_001F);
    repeat (2) @(posedge clk_i);
    check(32'(irq), 32'h0000_0001);
    wr(PWT_IDX_STAT, 32'h0000_001F);
    repeat (2) @(posedge clk_i);
    check(32'(irq), 32'h0000_0000);
    // Acquisition from each start source
    for (int i = 0; i < 4; i++) begin
      wr(PWT_IDX_CTL0 + 6'(i), 32'h0000_0000);
      set_width(i, 32'h0000_0000);
    end
    wr(PWT_IDX_CTL2, 32'h0064_0001);
    wr(PWT_IDX_MULT, 32'h0000_0001);
    for (int s = 0; s < 4; s++) begin
      wr(PWT_IDX_STAT, 32'h0000_001F);
      wr(PWT_IDX_ACQ, 32'h0000_0001);
      if (s == 3) begin
        set_width(2, 32'h0000_01F4);
      end else begin
        @(posedge clk_i);
        dig <= (s == 0);
        adc <= (s == 1);
        enc <= (s == 2);
        @(posedge clk_i);
        dig <= 1'b0;
        adc <= 1'b0;
        enc <= 1'b0;
      end
      wait_start(got);
      check(32'(got), 32'h0000_0001);
      if (s == 0) begin
        count_sclk(q);
        check(q, 32'h0000_0064);
        count_sclk(q);
        check(q, 32'h0000_0064);
      end
      rd(PWT_IDX_ACQ, q);
      check(q, 32'h0000_0003);
      rd(PWT_IDX_STAT, q);
      check(q, (s == 3) ? 32'h0000_0014 : 32'h0000_0010);
      wr(PWT_IDX_ACQ, 32'h0000_0000);
      repeat (2) @(posedge clk_i);
      check(32'(acq_active), 32'h0000_0000);
    end
    complete_run();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end
endmodule
